// file: design/decimal_component_multiplier.sv
// Digit-serial decimal multiplier adding right- and left-hand components per multiplier digit.
// Assumes the host loads multiplicand, multiplier and shift before pulsing start.
`timescale 1ns/10ps
// Function
// - Each multiplier digit adds one right and one left component.
// - Two drive cycles per digit: two accumulator cycles, one components cycle.
// - Right stroke in first half of components cycle, left in second.
// - One extra right and left stroke after last digit, round-off/clear there.
// - Each drive trip runs one drive and accumulator cycle, 180 degrees.
// - Right stroke: route 14 deg, gate 15 deg, accumulate from 30 deg.
// - Left stroke: route 194 deg, accumulate from 210 deg.
// - Drive not tripped until table and shifter selections are positioned.
// - Nine pulses: eight breaking contacts, gate switch sets the ninth.
// - Each pulse advances its accumulator column by its length.
// - Function table maps nine pulses to nine bus lines per digit.
// - Each multiplicand column routes the pulse of its stored digit.
// - Shifter places multiplicand columns on consecutive accumulator columns.
// - Zero multiplier digits are skipped in no significant time.
// - Left-hand strokes shift one column further left.
module decimal_component_multiplier #(
  parameter int MC_N   = dcm_pkg::MC_DIGITS,
  parameter int MP_N   = dcm_pkg::MP_DIGITS,
  parameter int ACC_N  = dcm_pkg::ACC_DIGITS,
  parameter int DEG_CY = dcm_pkg::DEG_CYC
) (
  input  wire logic                    clk,           // 25 MHz clock
  input  wire logic                    rst,           // Async reset, high
  input  wire logic                    start,         // One-cycle start pulse
  input  wire logic [4*MC_N-1:0]       multiplicand,  // BCD, digit 0 is units
  input  wire logic [4*MP_N-1:0]       multiplier,    // BCD, digit 0 first
  input  wire logic [dcm_pkg::SHIFT_W-1:0] shift,     // Right-hand column of mc digit 0
  input  wire logic                    roundOn,       // Add five below round column
  input  wire logic                    clearOn,       // Clear low columns on final left
  input  wire logic [dcm_pkg::SHIFT_W-1:0] roundCol,  // Round-off column
  output logic [4*ACC_N-1:0]           product,       // BCD product accumulator
  output logic                         busy,          // Multiplication running
  output logic                         done,          // One-cycle completion pulse
  output logic                         drive_trip_coil, // One-cycle stroke trip
  output logic                         pulse_gate_switch, // Nine pulse gate
  output dcm_pkg::strokeFlags_t        flags          // Stroke status
);
  localparam int DEG_W = 9;
  localparam int DIG_W = $clog2(MP_N + 1);
  localparam int SEL_W = 7;

  dcm_pkg::stroke_t     state, next_state;
  logic [DIG_W-1:0]     digitIdx, next_digitIdx;
  logic [DEG_W-1:0]     angle, next_angle;
  logic [15:0]          subCnt, next_subCnt;
  logic [2:0]           posCnt, next_posCnt;
  logic [3:0]           selDigit, next_selDigit;
  logic                 finalPair, next_finalPair;
  logic [4*ACC_N-1:0]   next_product;
  logic                 next_busy, next_done, next_trip, next_gate;
  dcm_pkg::strokeFlags_t next_flags;
  logic [SEL_W-1:0]     shiftSel, next_shiftSel;
  logic [15:0]          tickCnt, next_tickCnt;
  logic [3:0]           unitIdx, next_unitIdx;
  logic                 unitTick;
  logic [3:0]           accAdd [ACC_N];
  logic [ACC_N-1:0]     colPulse;
  logic [8:0]           pulses;
  logic                 pulseRun;

  pulse_source #(.UNIT_CYC(DEG_CY)) u_pulse (
    .clk    (clk),
    .rst    (rst),
    .gateOn (pulseRun),
    .pulses (pulses)
  );

  function automatic logic [3:0] mpDigit(input logic [4*MP_N-1:0] v, input int i);
    mpDigit = v[4*i +: 4];
  endfunction : mpDigit

  // Pulses run only while the gate is closed and the cam is in its window
  assign pulseRun = pulse_gate_switch && flags.accumulating;

  // table, stored digit and shifter per column
  for (genvar c = 0; c < ACC_N; c++) begin : g_col
    always_comb begin
      int         m;
      logic [7:0] prod;
      m         = c - int'(shiftSel);
      prod      = 8'h00;
      accAdd[c] = 4'h0;
      if (!finalPair && m >= 0 && m < MC_N) begin
        // Right stroke adds the units of each digit product, left the tens
        prod      = 8'(multiplicand[4*m +: 4]) * 8'(selDigit);
        accAdd[c] = flags.leftHand ? 4'(prod / 8'h0A) : 4'(prod % 8'h0A);
      end else if (finalPair && !flags.leftHand && roundOn && int'(roundCol) == c + 1) begin
        // round-off five below the round column
        accAdd[c] = 4'h5;
      end
    end
    // column takes the pulse whose length is its component
    assign colPulse[c] = |({pulses, 1'b0} & (10'h001 << accAdd[c]));
  end

  // length units counted exactly as the pulse source counts them
  always_comb begin
    next_tickCnt = '0;
    next_unitIdx = '0;
    unitTick     = 1'b0;
    if (pulseRun) begin
      next_tickCnt = tickCnt + 16'h1;
      next_unitIdx = unitIdx;
      if (tickCnt == 16'(DEG_CY - 1)) begin
        next_tickCnt = '0;
        // Ninth pulse is the gate itself, so stop after nine units
        if (unitIdx != 4'h9) begin
          unitTick     = 1'b1;
          next_unitIdx = unitIdx + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
      unitIdx <= 4'h0;
    end else begin
      tickCnt <= next_tickCnt;
      unitIdx <= next_unitIdx;
    end
  end

  always_comb begin
    next_state     = state;
    next_digitIdx  = digitIdx;
    next_angle     = angle;
    next_subCnt    = subCnt;
    next_posCnt    = posCnt;
    next_selDigit  = selDigit;
    next_shiftSel  = shiftSel;
    next_finalPair = finalPair;
    next_product   = product;
    next_busy      = busy;
    next_done      = 1'b0;
    next_trip      = 1'b0;
    next_gate      = pulse_gate_switch;
    next_flags     = flags;
    unique case (state)
      dcm_pkg::ST_HOME: begin
        if (start) begin
          next_busy      = 1'b1;
          next_digitIdx  = '0;
          next_finalPair = 1'b0;
          next_product   = '0;
          next_posCnt    = '0;
          next_state     = dcm_pkg::ST_POS_R;
        end
      end
      dcm_pkg::ST_POS_R: begin
        if (!finalPair && digitIdx < DIG_W'(MP_N)
            && mpDigit(multiplier, int'(digitIdx)) == 4'h0) begin
          next_digitIdx = digitIdx + 1'b1;
          next_posCnt   = '0;
        end else if (!finalPair && digitIdx == DIG_W'(MP_N)) begin
          // extra stroke pair after last digit
          next_finalPair = 1'b1;
          next_posCnt    = '0;
        end else if (posCnt == 3'(dcm_pkg::POS_CYC)) begin
          next_trip        = 1'b1;
          next_angle       = '0;
          next_subCnt      = '0;
          next_flags.leftHand  = 1'b0;
          next_flags.finalPair = finalPair;
          next_state       = dcm_pkg::ST_STROKE_R;
        end else begin
          next_selDigit = finalPair ? 4'h0 : mpDigit(multiplier, int'(digitIdx));
          // shifter steps one column per multiplier digit
          next_shiftSel = SEL_W'(shift) + SEL_W'(digitIdx);
          next_posCnt   = posCnt + 3'h1;
        end
      end
      dcm_pkg::ST_POS_L: begin
        if (posCnt == 3'(dcm_pkg::POS_CYC)) begin
          next_trip            = 1'b1;
          next_flags.leftHand  = 1'b1;
          next_subCnt          = '0;
          next_state           = dcm_pkg::ST_STROKE_L;
        end else begin
          // left shifter one column further left
          next_shiftSel = SEL_W'(shift) + SEL_W'(digitIdx) + SEL_W'(1);
          next_posCnt = posCnt + 3'h1;
        end
      end
      dcm_pkg::ST_STROKE_R, dcm_pkg::ST_STROKE_L: begin
        // each trip sweeps half a revolution
        if (subCnt == 16'(DEG_CY - 1)) begin
          next_subCnt = '0;
          next_angle  = angle + 1'b1;
        end else begin
          next_subCnt = subCnt + 16'h1;
        end
        next_flags.routeClosed  = state == dcm_pkg::ST_STROKE_R
          ? (angle >= DEG_W'(dcm_pkg::ROUTE_DEG_R)) : (angle >= DEG_W'(dcm_pkg::ROUTE_DEG_L));
        next_gate = state == dcm_pkg::ST_STROKE_R
          ? (angle >= DEG_W'(dcm_pkg::GATE_DEG_R)
             && angle < DEG_W'(dcm_pkg::GATE_DEG_R + dcm_pkg::ACC_LEN_DEG))
          : (angle >= DEG_W'(dcm_pkg::GATE_DEG_L)
             && angle < DEG_W'(dcm_pkg::GATE_DEG_L + dcm_pkg::ACC_LEN_DEG));
        next_flags.gateOn = next_gate;
        next_flags.accumulating = state == dcm_pkg::ST_STROKE_R
          ? (angle >= DEG_W'(dcm_pkg::ACC_DEG_R)
             && angle < DEG_W'(dcm_pkg::GATE_DEG_R + dcm_pkg::ACC_LEN_DEG))
          : (angle >= DEG_W'(dcm_pkg::ACC_DEG_L)
             && angle < DEG_W'(dcm_pkg::GATE_DEG_L + dcm_pkg::ACC_LEN_DEG));
        // every lit column steps once per length unit
        if (unitTick) begin
          next_product = bcdAdd(product, colPulse);
        end
        // right ends at 180, left at 360
        if (state == dcm_pkg::ST_STROKE_R && angle == DEG_W'(dcm_pkg::HALF_DEG)) begin
          next_posCnt = '0;
          next_angle  = DEG_W'(dcm_pkg::HALF_DEG);
          next_gate   = 1'b0;
          next_flags.routeClosed = 1'b0;
          next_flags.gateOn      = 1'b0;
          next_state  = dcm_pkg::ST_POS_L;
        end else if (state == dcm_pkg::ST_STROKE_L
                     && angle == DEG_W'(2 * dcm_pkg::HALF_DEG)) begin
          // digit done after full components cycle
          next_gate   = 1'b0;
          next_flags.routeClosed = 1'b0;
          next_flags.gateOn      = 1'b0;
          next_posCnt = '0;
          if (finalPair) begin
            next_state = dcm_pkg::ST_DONE;
          end else begin
            next_digitIdx = digitIdx + 1'b1;
            next_state    = dcm_pkg::ST_POS_R;
          end
        end
      end
      dcm_pkg::ST_DONE: begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_flags = '0;
        next_state = dcm_pkg::ST_HOME;
      end
      default: next_state = dcm_pkg::ST_HOME;
    endcase
  end

  // One length-unit step: lit columns advance by one, carries ripple up;
  // the final left stroke clears the columns below the round column
  function automatic logic [4*ACC_N-1:0] bcdAdd(input logic [4*ACC_N-1:0] acc,
                                                input logic [ACC_N-1:0]   inc);
    logic [4:0] s;
    logic       cy;
    cy = 1'b0;
    for (int c = 0; c < ACC_N; c++) begin
      s = 5'(acc[4*c +: 4]) + 5'(inc[c]) + 5'(cy);
      cy = s > 5'h09;
      bcdAdd[4*c +: 4] = cy ? 4'(s - 5'h0A) : s[3:0];
      if (finalPair && flags.leftHand && clearOn && c < int'(roundCol)) begin
        bcdAdd[4*c +: 4] = 4'h0;
      end
    end
  endfunction : bcdAdd

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state             <= dcm_pkg::ST_HOME;
      digitIdx          <= '0;
      angle             <= '0;
      subCnt            <= '0;
      posCnt            <= '0;
      selDigit          <= 4'h0;
      shiftSel          <= '0;
      finalPair         <= 1'b0;
      product           <= '0;
      busy              <= 1'b0;
      done              <= 1'b0;
      drive_trip_coil   <= 1'b0;
      pulse_gate_switch <= 1'b0;
      flags             <= '0;
    end else begin
      state             <= next_state;
      digitIdx          <= next_digitIdx;
      angle             <= next_angle;
      subCnt            <= next_subCnt;
      posCnt            <= next_posCnt;
      selDigit          <= next_selDigit;
      shiftSel          <= next_shiftSel;
      finalPair         <= next_finalPair;
      product           <= next_product;
      busy              <= next_busy;
      done              <= next_done;
      drive_trip_coil   <= next_trip;
      pulse_gate_switch <= next_gate;
      flags             <= next_flags;
    end
  end
endmodule : decimal_component_multiplier

// file: design/dcm_pkg.sv
// Package for the decimal component multiplier: widths, angles, timing counts, types.
// Assumes a single 25 MHz clock and a host that loads operands before start.
package dcm_pkg;
  localparam int CLK_MHZ        = 25;
  // One degree of the components cycle, in ns (scaled model of the cam shaft)
  localparam int DEG_NS         = 80;
  localparam int DEG_CYC        = (DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_DEG       = 180;
  localparam int ROUTE_DEG_R    = 14;
  localparam int GATE_DEG_R     = 15;
  localparam int ACC_DEG_R      = 30;
  localparam int ROUTE_DEG_L    = 194;
  localparam int GATE_DEG_L     = 195;
  localparam int ACC_DEG_L      = 210;
  localparam int ACC_LEN_DEG    = 90;
  localparam int POS_CYC        = 4;
  localparam int MC_DIGITS      = 12;
  localparam int MP_DIGITS      = 12;
  localparam int ACC_DIGITS     = 24;
  localparam int SHIFT_W        = 5;
  localparam int PULSES         = 9;

  typedef enum {
    ST_HOME, ST_POS_R, ST_STROKE_R, ST_POS_L, ST_STROKE_L, ST_DONE
  } stroke_t;

  typedef struct packed {
    logic        routeClosed;
    logic        gateOn;
    logic        accumulating;
    logic        leftHand;
    logic        finalPair;
  } strokeFlags_t;
endpackage : dcm_pkg

// file: design/pulse_source.sv
// Nine-length pulse source: pulse k stays high for k length units after the gate opens.
// Assumes the caller holds gateOn for the whole accumulation window.
`timescale 1ns/10ps
module pulse_source #(
  parameter int UNIT_CYC = 10
) (
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Async reset, high
  input  wire logic       gateOn,   // Pulse gate switch closed
  output logic [8:0]      pulses    // Pulse k-1 high for k units
);
  logic [7:0] unitCnt;
  logic [7:0] next_unitCnt;
  logic [3:0] lenCnt;
  logic [3:0] next_lenCnt;

  always_comb begin
    next_unitCnt = unitCnt;
    next_lenCnt  = lenCnt;
    if (!gateOn) begin
      next_unitCnt = 8'h00;
      next_lenCnt  = 4'h0;
    end else if (lenCnt != 4'h9) begin
      if (unitCnt == 8'(UNIT_CYC - 1)) begin
        next_unitCnt = 8'h00;
        next_lenCnt  = lenCnt + 4'h1;
      end else begin
        next_unitCnt = unitCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unitCnt <= 8'h00;
      lenCnt  <= 4'h0;
    end else begin
      unitCnt <= next_unitCnt;
      lenCnt  <= next_lenCnt;
    end
  end

  // eight breaking contacts, gate sets ninth
  for (genvar k = 0; k < 8; k++) begin : g_break
    assign pulses[k] = gateOn && (lenCnt < 4'(k + 1));
  end
  assign pulses[8] = gateOn;
endmodule : pulse_source

// file: test/host_op.svh
// Operand set the host loads into the multiplier before a run.
// Assumes twelve multiplicand and twelve multiplier digits.
`ifndef HOST_OP_SVH
`define HOST_OP_SVH
typedef struct packed {
  logic [47:0]                   mc;       // BCD multiplicand
  logic [47:0]                   mp;       // BCD multiplier
  logic [dcm_pkg::SHIFT_W-1:0]   sh;       // Right-hand shift
  logic [dcm_pkg::SHIFT_W-1:0]   roundCol; // Round-off column
  logic                          roundOn;  // Round enabled
  logic                          clearOn;  // Clear enabled
} hostOp_t;
`endif

// file: test/dcm_props.sv
// Port checker for the decimal component multiplier, bound to its top.
// Assumes DEG_CY of 1, so one degree of the cycle is one clock.
`timescale 1ns/10ps
module dcm_props #(
  parameter int MC_N   = 12,
  parameter int MP_N   = 12,
  parameter int ACC_N  = 24,
  parameter int DEG_CY = 1
) (
  input wire logic                          clk,               // Clock
  input wire logic                          rst,               // Reset
  input wire logic                          start,             // Start pulse
  input wire logic [4*ACC_N-1:0]            product,           // Accumulator
  input wire logic                          busy,              // Running
  input wire logic                          done,              // Finished
  input wire logic                          drive_trip_coil,   // Stroke trip
  input wire logic                          pulse_gate_switch, // Pulse gate
  input wire dcm_pkg::strokeFlags_t         flags              // Stroke status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_trip; drive_trip_coil; endsequence
  sequence s_gateOpen; $rose(pulse_gate_switch); endsequence
  a_trip_spacing: assert property (s_trip |=> !drive_trip_coil [*8])
    else $error("trip not a lone pulse");
  a_trip_busy: assert property (s_trip |-> busy)
    else $error("trip while idle");
  a_gate_late: assert property (s_trip |=> !pulse_gate_switch [*8])
    else $error("gate opened too early");
  a_gate_opens: assert property (s_trip |-> ##[10:40] pulse_gate_switch)
    else $error("gate did not open");
  a_route_closes: assert property (s_trip |-> ##[10:20] flags.routeClosed)
    else $error("route not closed");
  a_gate_width: assert property (s_gateOpen |-> pulse_gate_switch [*8])
    else $error("gate window too short");
  a_sum_waits: assert property (s_trip |=> $stable(product) [*8])
    else $error("accumulated before pulses");
  a_left_busy: assert property ($rose(flags.leftHand) |-> busy && !done)
    else $error("left stroke outside a run");
  a_done_ends: assert property (done |=> !done && !busy)
    else $error("done not a closing pulse");
  a_start_taken: assert property (start && !busy |=> busy)
    else $error("start not taken");
  a_idle_hold: assert property (!busy && !start |=> $stable(product))
    else $error("product moved while idle");
endmodule : dcm_props

bind decimal_component_multiplier dcm_props #(
  .MC_N(MC_N), .MP_N(MP_N), .ACC_N(ACC_N), .DEG_CY(DEG_CY)
) dcm_props_i (
  .clk(clk), .rst(rst), .start(start), .product(product), .busy(busy), .done(done),
  .drive_trip_coil(drive_trip_coil), .pulse_gate_switch(pulse_gate_switch), .flags(flags)
);

// file: test/host_model.sv
// Host model: latches operands and then pulses start one clock later.
// Assumes the bench asks for runs by pulsing go.
`timescale 1ns/10ps
`include "host_op.svh"
module host_model (
  input  wire logic    clk,   // Clock
  input  wire logic    rst,   // Async reset, high
  input  wire logic    go,    // Run request from bench
  input  wire logic    busy,  // Multiplier running
  input  wire hostOp_t opIn,  // Next operand set
  output logic         start, // Start pulse
  output hostOp_t      op     // Operands at the pins
);
  hostOp_t next_op;
  logic    goSeen;
  always_comb begin
    next_op = op;
    if (go && !busy) next_op = opIn;
  end
  // A go while busy still pulses start but never touches held operands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op <= '0;
      goSeen <= 1'b0;
      start <= 1'b0;
    end else begin
      op <= next_op;
      goSeen <= go;
      start <= goSeen;
    end
  end
endmodule : host_model

// file: test/tb_top.sv
// Self-checking bench: runs multiplications and checks product and stroke count.
// Assumes DEG_CY of 1 to keep each stroke near 181 clocks.
`timescale 1ns/10ps
`include "host_op.svh"
module tb_top;
  typedef struct {logic [95:0] prod; logic [7:0] trips;} note_t;
  logic clk, rst, go, start, busy, done, trip, gate;
  logic [95:0] product;
  hostOp_t opIn, op;
  dcm_pkg::strokeFlags_t flags;
  int failures, check_count, seed, trips, k;
  note_t notes[$];
  note_t seen;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  host_model host_model_i (.clk(clk), .rst(rst), .go(go), .busy(busy), .opIn(opIn),
    .start(start), .op(op));
  decimal_component_multiplier #(.DEG_CY(1)) decimal_component_multiplier_i (
    .clk(clk), .rst(rst), .start(start), .multiplicand(op.mc), .multiplier(op.mp),
    .shift(op.sh), .roundOn(op.roundOn), .clearOn(op.clearOn), .roundCol(op.roundCol),
    .product(product), .busy(busy), .done(done), .drive_trip_coil(trip),
    .pulse_gate_switch(gate), .flags(flags));
  task automatic cmp_prod(input string what, input logic [95:0] exp, input logic [95:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_prod
  task automatic cmp_cnt(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_cnt
  function automatic logic [95:0] to_bcd(input logic [127:0] v);
    logic [95:0] b;
    b = '0;
    for (int i = 0; i < 24; i++) begin
      b[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return b;
  endfunction : to_bcd
  function automatic logic [127:0] p10(input int n);
    logic [127:0] r;
    r = 128'h1;
    for (int i = 0; i < n; i++) r = r * 10;
    return r;
  endfunction : p10
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic run(input logic [127:0] mcV, input logic [127:0] mpV, input int sh,
                     input int rc, input logic ro, input logic cl, input logic stray);
    hostOp_t o;
    note_t n;
    logic [95:0] b;
    logic [127:0] v;
    int i;
    b = to_bcd(mcV);
    o.mc = b[47:0];
    b = to_bcd(mpV);
    o.mp = b[47:0];
    o.sh = 5'(sh);
    o.roundCol = 5'(rc);
    o.roundOn = ro;
    o.clearOn = cl;
    n.trips = 8'h02;
    for (i = 0; i < 12; i++) if (o.mp[4*i +: 4] != 4'h0) n.trips = n.trips + 8'h02;
    v = mcV * mpV * p10(sh);
    if (ro) v = v + 5 * p10(rc - 1);
    if (cl) v = v - v % p10(rc);
    n.prod = to_bcd(v);
    notes.push_back(n);
    @(posedge clk) go <= 1'b1;
    opIn <= o;
    @(posedge clk) go <= 1'b0;
    if (stray) begin
      repeat (60) @(posedge clk);
      go <= 1'b1;
      opIn <= ~o;
      @(posedge clk) go <= 1'b0;
    end
    for (i = 0; i < 20000; i++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    if (i == 20000) begin
      failures++;
      report_and_stop();
    end else begin
      $display("test %0d ended", k++);
    end
  endtask : run
  // Oldest note is taken at each done pulse
  always @(negedge clk) begin
    if (rst) trips = 0;
    else begin
      if (trip === 1'b1) trips++;
      if (done === 1'b1 && notes.size() > 0) begin
        seen = notes.pop_front();
        cmp_prod("product", seen.prod, product);
        cmp_cnt("strokes", seen.trips, trips[7:0]);
        trips = 0;
      end
    end
  end
  initial begin
    seed = 80351;
    rst = 1'b1;
    go = 1'b0;
    opIn = '0;
    failures = 0;
    check_count = 0;
    trips = 0;
    k = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    run(128'd123456789, 128'd3, 2, 1, 1'b0, 1'b0, 1'b0);
    run(128'd999999999999, 128'd909, 0, 1, 1'b0, 1'b0, 1'b1);
    run(128'd4321, 128'd0, 3, 2, 1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++) begin
      run(128'({$random(seed)} % 1000000) * 128'd1000000 + 128'({$random(seed)} % 1000000),
          128'({$random(seed)} % 1000), {$random(seed)} % 5, 1 + {$random(seed)} % 4,
          1'($random(seed)), 1'($random(seed)), 1'b0);
    end
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    notes.delete();
    @(posedge clk) rst <= 1'b0;
    @(negedge clk);
    cmp_cnt("busy", 8'h00, {7'h00, busy});
    cmp_prod("product", 96'h0, product);
    run(128'd5, 128'd7, 0, 1, 1'b0, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
